/* File: hw/ald_decoder.sv */
// Registered decoder for the arithmetic and logical instruction group
`timescale 1ns/1ps

// How it works
// - Opcodes 28-2F, 25, 26-27 and 24 decode as add to the accumulator.
// - Opcodes 38-3F, 35, 36-37 and 34 decode as add with carry.
// - Opcodes 98-9F, 95, 96-97 and 94 decode as subtract with borrow.
// - Register, pointer forms: 1 byte; direct, immediate: 2; all 1 cycle.
// - Opcodes 58-5F, 55, 56-57 and 54: one-cycle AND into the accumulator.
// - 52 ANDs acc into direct: 2 bytes, 1 cycle; 53 ANDs immediate: 3, 2.
// - Opcodes 48-4F, 45, 46-47 and 44: one-cycle OR into the accumulator.
// - 42 ORs acc into direct: 2 bytes, 1 cycle; 43 ORs immediate: 3, 2.
module ald_decoder (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        opcode_valid_i,
  input  wire logic [7:0]  opcode_i,
  output ald_pkg::ald_ctrl_s ctrl_o,
  output logic             unknown_o
);

  // ==========================================================================
  // All checks below run on the core clock and pause during reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // Operand form of the low nibble
  logic [3:0]          hi;
  logic [3:0]          lo;
  ald_pkg::ald_src_e   form_src;
  logic [2:0]          form_sel;
  logic [1:0]          form_bytes;
  logic                form_hit;

  assign hi = opcode_i[ald_pkg::ALD_HI_MSB:ald_pkg::ALD_HI_LSB];
  assign lo = opcode_i[ald_pkg::ALD_LO_MSB:ald_pkg::ALD_LO_LSB];

  ald_form_decode u_form (
    .lo_i    (lo),
    .src_o   (form_src),
    .sel_o   (form_sel),
    .bytes_o (form_bytes),
    .hit_o   (form_hit)
  );

  // ==========================================================================
  // Next decoded controls
  ald_pkg::ald_ctrl_s ctrl_d, ctrl_q;
  logic               unknown_d, unknown_q;

  always_comb begin
    ctrl_d        = '0;
    ctrl_d.op     = ald_pkg::ALD_OP_NONE;
    ctrl_d.src    = form_src;
    ctrl_d.dst    = ald_pkg::ALD_DST_ACC;
    ctrl_d.sel    = form_sel;
    ctrl_d.bytes  = form_bytes;
    ctrl_d.cycles = ald_pkg::ALD_CYC1;
    unknown_d     = 1'b0;
    if (opcode_valid_i) begin
      ctrl_d.valid = 1'b1;
      if (opcode_i == ald_pkg::ALD_OPC_INC_POINTER) begin
        ctrl_d.op     = ald_pkg::ALD_OP_INC_DATA_POINTER;
        ctrl_d.src    = ald_pkg::ALD_SRC_NONE;
        ctrl_d.dst    = ald_pkg::ALD_DST_NONE;
        ctrl_d.bytes  = ald_pkg::ALD_LEN1;
        ctrl_d.cycles = ald_pkg::ALD_CYC2;
      end else if (opcode_i == ald_pkg::ALD_OPC_MULTIPLY ||
                   opcode_i == ald_pkg::ALD_OPC_DIVIDE) begin
        ctrl_d.op     = (opcode_i == ald_pkg::ALD_OPC_MULTIPLY) ?
                        ald_pkg::ALD_OP_MULTIPLY_ACC_AUX :
                        ald_pkg::ALD_OP_DIVIDE_ACC_AUX;
        ctrl_d.src    = ald_pkg::ALD_SRC_ACC;
        ctrl_d.bytes  = ald_pkg::ALD_LEN1;
        ctrl_d.cycles = ald_pkg::ALD_CYC4;
      end else if (opcode_i == ald_pkg::ALD_OPC_BCD_ADJUST) begin
        ctrl_d.op    = ald_pkg::ALD_OP_DECIMAL_ADJUST_ACC;
        ctrl_d.src   = ald_pkg::ALD_SRC_ACC;
        ctrl_d.bytes = ald_pkg::ALD_LEN1;
      end else if ((hi == ald_pkg::ALD_HI_INC || hi == ald_pkg::ALD_HI_DECR)
                   && (form_hit || lo == ald_pkg::ALD_LO_IMM)) begin
        ctrl_d.op = (hi == ald_pkg::ALD_HI_INC) ? ald_pkg::ALD_OP_INCREMENT
                    : ald_pkg::ALD_OP_DECREMENT_OP;
        if (lo == ald_pkg::ALD_LO_IMM) begin
          ctrl_d.src   = ald_pkg::ALD_SRC_ACC; // x4 is the accumulator form
          ctrl_d.bytes = ald_pkg::ALD_LEN1;
        end
        ctrl_d.dst = (lo == ald_pkg::ALD_LO_IMM) ? ald_pkg::ALD_DST_ACC
                     : ald_pkg::ALD_DST_OPERAND;
      end else if ((hi == ald_pkg::ALD_HI_AND || hi == ald_pkg::ALD_HI_OR) &&
                   (lo == ald_pkg::ALD_LO_TO_DIR_ACC ||
                    lo == ald_pkg::ALD_LO_TO_DIR_IMM)) begin
        ctrl_d.op = (hi == ald_pkg::ALD_HI_AND) ?
                    ald_pkg::ALD_OP_BITWISE_AND_OP :
                    ald_pkg::ALD_OP_BITWISE_OR_OP;
        ctrl_d.dst = ald_pkg::ALD_DST_DIRECT;
        ctrl_d.sel = ald_pkg::ALD_SEL0;
        if (lo == ald_pkg::ALD_LO_TO_DIR_ACC) begin
          ctrl_d.src   = ald_pkg::ALD_SRC_ACC;
          ctrl_d.bytes = ald_pkg::ALD_LEN2;
        end else begin
          ctrl_d.src    = ald_pkg::ALD_SRC_IMMEDIATE;
          ctrl_d.bytes  = ald_pkg::ALD_LEN3;
          ctrl_d.cycles = ald_pkg::ALD_CYC2;
        end
      end else if (form_hit) begin
        unique case (hi)
          ald_pkg::ALD_HI_ADD:  ctrl_d.op = ald_pkg::ALD_OP_ADD;
          ald_pkg::ALD_HI_CARRY_ADD: begin
            ctrl_d.op = ald_pkg::ALD_OP_ADD_WITH_CARRY;
          end
          ald_pkg::ALD_HI_BORROW_SUB: begin
            ctrl_d.op = ald_pkg::ALD_OP_SUBTRACT_WITH_BORROW;
          end
          ald_pkg::ALD_HI_AND: begin
            ctrl_d.op = ald_pkg::ALD_OP_BITWISE_AND_OP;
          end
          ald_pkg::ALD_HI_OR: begin
            ctrl_d.op = ald_pkg::ALD_OP_BITWISE_OR_OP;
          end
          default: ctrl_d.op = ald_pkg::ALD_OP_NONE;
        endcase
      end
      if (ctrl_d.op == ald_pkg::ALD_OP_NONE) begin
        ctrl_d    = '0;
        unknown_d = 1'b1; // Outside this group
      end
    end else begin
      ctrl_d = '0;
    end
  end

  // Register the decoded controls
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q    <= '0;
      unknown_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      unknown_q <= unknown_d;
    end
  end

  assign ctrl_o    = ctrl_q;
  assign unknown_o = unknown_q;

  // ==========================================================================
  // Checks on decoded output, one cycle after the opcode
  sequence s_op_in(logic [7:0] v);
    opcode_valid_i && opcode_i == v;
  endsequence

  a_add_reg: assert property (
    s_op_in(8'h2A) |=> ctrl_o.op == ald_pkg::ALD_OP_ADD && ctrl_o.sel == 3'h2
      && ctrl_o.bytes == 2'h1 && ctrl_o.dst == ald_pkg::ALD_DST_ACC)
    else $error("add register decode wrong");
  a_add_dir: assert property (
    s_op_in(8'h25) |=> ctrl_o.op == ald_pkg::ALD_OP_ADD
      && ctrl_o.src == ald_pkg::ALD_SRC_DIRECT && ctrl_o.bytes == 2'h2)
    else $error("add direct decode wrong");
  a_carry_dir: assert property (
    s_op_in(8'h35) |=> ctrl_o.op == ald_pkg::ALD_OP_ADD_WITH_CARRY
      && ctrl_o.src == ald_pkg::ALD_SRC_DIRECT && ctrl_o.bytes == 2'h2)
    else $error("add with carry direct decode wrong");
  a_borrow_ind: assert property (
    s_op_in(8'h97) |=> ctrl_o.op == ald_pkg::ALD_OP_SUBTRACT_WITH_BORROW
      && ctrl_o.sel == 3'h1 && ctrl_o.bytes == 2'h1)
    else $error("subtract indirect decode wrong");
  a_arith_len: assert property (
    opcode_valid_i && opcode_i[3:0] == 4'h4
      && opcode_i[7:4] inside {4'h2, 4'h3, 4'h9}
      |=> ctrl_o.bytes == 2'h2 && ctrl_o.cycles == 3'h1
      && ctrl_o.src == ald_pkg::ALD_SRC_IMMEDIATE)
    else $error("immediate arithmetic length wrong");
  a_and_acc: assert property (
    s_op_in(8'h5F) |=> ctrl_o.op == ald_pkg::ALD_OP_BITWISE_AND_OP
      && ctrl_o.sel == 3'h7 && ctrl_o.dst == ald_pkg::ALD_DST_ACC)
    else $error("and register decode wrong");
  a_and_dir_imm: assert property (
    s_op_in(8'h53) |=> ctrl_o.bytes == 2'h3 && ctrl_o.cycles == 3'h2
      && ctrl_o.dst == ald_pkg::ALD_DST_DIRECT)
    else $error("and to direct decode wrong");
  a_and_dir_acc: assert property (
    s_op_in(8'h52) |=> ctrl_o.op == ald_pkg::ALD_OP_BITWISE_AND_OP
      && ctrl_o.src == ald_pkg::ALD_SRC_ACC && ctrl_o.bytes == 2'h2
      && ctrl_o.dst == ald_pkg::ALD_DST_DIRECT)
    else $error("and accumulator to direct decode wrong");
  a_or_imm: assert property (
    s_op_in(8'h44) |=> ctrl_o.op == ald_pkg::ALD_OP_BITWISE_OR_OP
      && ctrl_o.bytes == 2'h2)
    else $error("or immediate decode wrong");
  a_or_dir_acc: assert property (
    s_op_in(8'h42) |=> ctrl_o.bytes == 2'h2 && ctrl_o.cycles == 3'h1
      && ctrl_o.src == ald_pkg::ALD_SRC_ACC)
    else $error("or to direct decode wrong");
  a_or_dir_imm: assert property (
    s_op_in(8'h43) |=> ctrl_o.op == ald_pkg::ALD_OP_BITWISE_OR_OP
      && ctrl_o.bytes == 2'h3 && ctrl_o.cycles == 3'h2
      && ctrl_o.src == ald_pkg::ALD_SRC_IMMEDIATE)
    else $error("or immediate to direct decode wrong");
  a_decr_dir: assert property (
    s_op_in(8'h15) |=> ctrl_o.op == ald_pkg::ALD_OP_DECREMENT_OP
      && ctrl_o.bytes == 2'h2 && ctrl_o.cycles == 3'h1)
    else $error("decrement direct decode wrong");
  a_inc_acc: assert property (
    s_op_in(8'h04) |=> ctrl_o.op == ald_pkg::ALD_OP_INCREMENT
      && ctrl_o.src == ald_pkg::ALD_SRC_ACC && ctrl_o.bytes == 2'h1
      && ctrl_o.dst == ald_pkg::ALD_DST_ACC)
    else $error("increment accumulator decode wrong");
  a_mul_cycles: assert property (
    s_op_in(8'hA4) |=> ctrl_o.cycles == 3'h4 && ctrl_o.valid)
    else $error("multiply cycles wrong");
  a_div_cycles: assert property (
    s_op_in(8'h84) |=> ctrl_o.op == ald_pkg::ALD_OP_DIVIDE_ACC_AUX
      && ctrl_o.cycles == 3'h4 && ctrl_o.bytes == 2'h1)
    else $error("divide cycles wrong");
  a_ptr_inc_cycles: assert property (
    s_op_in(8'hA3) |=> ctrl_o.op == ald_pkg::ALD_OP_INC_DATA_POINTER
      && ctrl_o.cycles == 3'h2)
    else $error("pointer increment cycles wrong");

endmodule : ald_decoder

/* File: hw/ald_pkg.sv */
// Package of opcode, field and length constants for the arithmetic decoder
package ald_pkg;

  // ==========================================================================
  // Operation and operand form enumerations
  typedef enum logic [3:0] {
    ALD_OP_NONE, ALD_OP_ADD, ALD_OP_ADD_WITH_CARRY,
    ALD_OP_SUBTRACT_WITH_BORROW,
    ALD_OP_INCREMENT, ALD_OP_DECREMENT_OP, ALD_OP_INC_DATA_POINTER,
    ALD_OP_MULTIPLY_ACC_AUX, ALD_OP_DIVIDE_ACC_AUX, ALD_OP_DECIMAL_ADJUST_ACC,
    ALD_OP_BITWISE_AND_OP, ALD_OP_BITWISE_OR_OP
  } ald_op_e;

  typedef enum logic [2:0] {
    ALD_SRC_NONE, ALD_SRC_ACC, ALD_SRC_BANK_REGISTER_OPERAND, ALD_SRC_DIRECT,
    ALD_SRC_POINTER_INDIRECT_OPERAND, ALD_SRC_IMMEDIATE
  } ald_src_e;

  typedef enum logic [1:0] {
    ALD_DST_NONE, ALD_DST_ACC, ALD_DST_OPERAND, ALD_DST_DIRECT
  } ald_dst_e;

  // ==========================================================================
  // Decoded control bundle
  typedef struct packed {
    logic     valid;
    ald_op_e  op;
    ald_src_e src;
    ald_dst_e dst;
    logic [2:0] sel;
    logic [1:0] bytes;
    logic [2:0] cycles;
  } ald_ctrl_s;

  // ==========================================================================
  // Opcode fields and group bases
  localparam int unsigned ALD_HI_MSB = 7;
  localparam int unsigned ALD_HI_LSB = 4;
  localparam int unsigned ALD_LO_MSB = 3;
  localparam int unsigned ALD_LO_LSB = 0;
  localparam int unsigned ALD_REG_BIT = 3;
  localparam int unsigned ALD_PTR_BIT = 0;

  localparam logic [3:0] ALD_HI_INC        = 4'h0;
  localparam logic [3:0] ALD_HI_DECR       = 4'h1;
  localparam logic [3:0] ALD_HI_ADD        = 4'h2;
  localparam logic [3:0] ALD_HI_CARRY_ADD  = 4'h3;
  localparam logic [3:0] ALD_HI_OR         = 4'h4;
  localparam logic [3:0] ALD_HI_AND        = 4'h5;
  localparam logic [3:0] ALD_HI_BORROW_SUB = 4'h9;

  localparam logic [3:0] ALD_LO_TO_DIR_ACC = 4'h2;
  localparam logic [3:0] ALD_LO_TO_DIR_IMM = 4'h3;
  localparam logic [3:0] ALD_LO_IMM        = 4'h4;
  localparam logic [3:0] ALD_LO_DIR        = 4'h5;
  localparam logic [3:0] ALD_LO_IND0       = 4'h6;
  localparam logic [3:0] ALD_LO_IND1       = 4'h7;

  localparam logic [7:0] ALD_OPC_INC_POINTER = 8'hA3;
  localparam logic [7:0] ALD_OPC_MULTIPLY    = 8'hA4;
  localparam logic [7:0] ALD_OPC_DIVIDE      = 8'h84;
  localparam logic [7:0] ALD_OPC_BCD_ADJUST  = 8'hD4;

  // ==========================================================================
  // Lengths and cycle counts
  localparam logic [1:0] ALD_LEN1 = 2'h1;
  localparam logic [1:0] ALD_LEN2 = 2'h2;
  localparam logic [1:0] ALD_LEN3 = 2'h3;
  localparam logic [2:0] ALD_CYC1 = 3'h1;
  localparam logic [2:0] ALD_CYC2 = 3'h2;
  localparam logic [2:0] ALD_CYC4 = 3'h4;
  localparam logic [2:0] ALD_SEL0 = 3'h0;

endpackage : ald_pkg

/* File: hw/ald_form_decode.sv */
// Operand form decoder shared by the five accumulator groups and the increment and decrement rows
`timescale 1ns/1ps

module ald_form_decode (
  input  wire logic [3:0]       lo_i,
  output ald_pkg::ald_src_e     src_o,
  output logic [2:0]            sel_o,
  output logic [1:0]            bytes_o,
  output logic                  hit_o
);

  // Low nibble: 4 immediate, 5 direct, 6-7 pointer, 8-F bank register
  always_comb begin
    src_o   = ald_pkg::ALD_SRC_NONE;
    sel_o   = ald_pkg::ALD_SEL0;
    bytes_o = ald_pkg::ALD_LEN1;
    hit_o   = 1'b1;
    if (lo_i[ald_pkg::ALD_REG_BIT]) begin
      src_o = ald_pkg::ALD_SRC_BANK_REGISTER_OPERAND;
      sel_o = lo_i[2:0];
    end else if (lo_i == ald_pkg::ALD_LO_IND0 ||
                 lo_i == ald_pkg::ALD_LO_IND1) begin
      src_o = ald_pkg::ALD_SRC_POINTER_INDIRECT_OPERAND;
      sel_o = {2'h0, lo_i[ald_pkg::ALD_PTR_BIT]};
    end else if (lo_i == ald_pkg::ALD_LO_DIR) begin
      src_o   = ald_pkg::ALD_SRC_DIRECT;
      bytes_o = ald_pkg::ALD_LEN2;
    end else if (lo_i == ald_pkg::ALD_LO_IMM) begin
      src_o   = ald_pkg::ALD_SRC_IMMEDIATE;
      bytes_o = ald_pkg::ALD_LEN2;
    end else begin
      hit_o = 1'b0;
    end
  end

endmodule : ald_form_decode

/* File: sim/ald_fetch_model.sv */
// Program fetch model that offers opcode bytes to the decoder
`timescale 1ns/1ps

module ald_fetch_model (
  input  wire logic  clk_i,
  output logic       opcode_valid_o,
  output logic [7:0] opcode_o
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    opcode_valid_o = 1'b0;
    opcode_o       = 8'h00;
  end

  // Offers one byte at the falling edge; an idle bus shows the inverted
  // last byte so a stale opcode is never mistaken for a fresh one
  task automatic send(input logic [7:0] opc, input logic vld);
    @(negedge clk_i);
    opcode_valid_o = vld;
    opcode_o       = vld ? opc : ~opcode_o;
  endtask : send
endmodule : ald_fetch_model

/* File: sim/tb.sv */
// Self-checking testbench for the arithmetic and logical decoder
`timescale 1ns/1ps

`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch %s expected %h seen %h", n, e, g); \
  end \
end

module tb;
  // ==========================================================================
  // Signals and counters
  localparam ald_pkg::ald_ctrl_s IDLE = '0;
  logic               clk_i;
  logic               reset_i;
  logic               opcode_valid;
  logic [7:0]         opcode;
  ald_pkg::ald_ctrl_s ctrl;
  logic               unknown;
  int                 error_cnt;
  int                 checks;

  // 100 ns clock
  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  ald_fetch_model u_fetch (
    .clk_i          (clk_i),
    .opcode_valid_o (opcode_valid),
    .opcode_o       (opcode)
  );

  ald_decoder u_dut (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .opcode_valid_i (opcode_valid),
    .opcode_i       (opcode),
    .ctrl_o         (ctrl),
    .unknown_o      (unknown)
  );

  // ==========================================================================
  // Expected control words
  function automatic ald_pkg::ald_ctrl_s mk(input ald_pkg::ald_op_e op,
      input ald_pkg::ald_src_e src, input ald_pkg::ald_dst_e dst,
      input logic [2:0] sel, input logic [1:0] len, input logic [2:0] cyc);
    mk = '{1'b1, op, src, dst, sel, len, cyc};
  endfunction : mk

  // Operand form chosen by the low nibble of a group opcode
  function automatic ald_pkg::ald_ctrl_s form(input ald_pkg::ald_op_e op,
      input logic [3:0] lo, input ald_pkg::ald_dst_e dst);
    if (lo >= 4'h8) begin
      form = mk(op, ald_pkg::ALD_SRC_BANK_REGISTER_OPERAND, dst, lo[2:0],
                2'h1, 3'h1);
    end else if (lo >= 4'h6) begin
      form = mk(op, ald_pkg::ALD_SRC_POINTER_INDIRECT_OPERAND, dst,
                {2'h0, lo[0]}, 2'h1, 3'h1);
    end else if (lo == 4'h5) begin
      form = mk(op, ald_pkg::ALD_SRC_DIRECT, dst, 3'h0, 2'h2, 3'h1);
    end else begin
      form = mk(op, ald_pkg::ALD_SRC_IMMEDIATE, dst, 3'h0, 2'h2, 3'h1);
    end
  endfunction : form

  // ==========================================================================
  // Vets one byte: offers it at a falling edge, checks the answer just after the next rising edge
  task automatic vet(input logic [7:0] opc, input logic vld,
      input ald_pkg::ald_ctrl_s exp, input logic unk);
    u_fetch.send(opc, vld);
    @(posedge clk_i);
    #1;
    `CHK("ctrl_o", exp, ctrl)
    `CHK("unknown_o", unk, unknown)
  endtask : vet

  // Every form of one accumulator group, back to back
  task automatic grp(input logic [3:0] hi, input ald_pkg::ald_op_e op);
    for (int lo = 4; lo < 16; lo++) begin
      vet({hi, lo[3:0]}, 1'b1, form(op, lo[3:0], ald_pkg::ALD_DST_ACC), 1'b0);
    end
  endtask : grp

  // Increment and decrement rows; x4 is the accumulator form
  task automatic step_ops;
    ald_pkg::ald_op_e   op;
    ald_pkg::ald_ctrl_s e;
    for (int h = 0; h < 2; h++) begin
      op = h ? ald_pkg::ALD_OP_DECREMENT_OP : ald_pkg::ALD_OP_INCREMENT;
      for (int lo = 4; lo < 16; lo++) begin
        e = form(op, lo[3:0], ald_pkg::ALD_DST_OPERAND);
        if (lo == 4) e = mk(op, ald_pkg::ALD_SRC_ACC, ald_pkg::ALD_DST_ACC,
                            3'h0, 2'h1, 3'h1);
        vet({h[3:0], lo[3:0]}, 1'b1, e, 1'b0);
      end
    end
  endtask : step_ops

  // Logical operations into a direct byte
  task automatic to_direct;
    vet(8'h52, 1'b1, mk(ald_pkg::ALD_OP_BITWISE_AND_OP, ald_pkg::ALD_SRC_ACC,
        ald_pkg::ALD_DST_DIRECT, 3'h0, 2'h2, 3'h1), 1'b0);
    vet(8'h53, 1'b1, mk(ald_pkg::ALD_OP_BITWISE_AND_OP,
        ald_pkg::ALD_SRC_IMMEDIATE, ald_pkg::ALD_DST_DIRECT, 3'h0, 2'h3,
        3'h2), 1'b0);
    vet(8'h42, 1'b1, mk(ald_pkg::ALD_OP_BITWISE_OR_OP, ald_pkg::ALD_SRC_ACC,
        ald_pkg::ALD_DST_DIRECT, 3'h0, 2'h2, 3'h1), 1'b0);
    vet(8'h43, 1'b1, mk(ald_pkg::ALD_OP_BITWISE_OR_OP,
        ald_pkg::ALD_SRC_IMMEDIATE, ald_pkg::ALD_DST_DIRECT, 3'h0, 2'h3,
        3'h2), 1'b0);
  endtask : to_direct

  // Single-opcode operations; all but D4 take more than one cycle
  task automatic specials;
    vet(8'hA3, 1'b1, mk(ald_pkg::ALD_OP_INC_DATA_POINTER,
        ald_pkg::ALD_SRC_NONE, ald_pkg::ALD_DST_NONE, 3'h0, 2'h1, 3'h2),
        1'b0);
    vet(8'hA4, 1'b1, mk(ald_pkg::ALD_OP_MULTIPLY_ACC_AUX, ald_pkg::ALD_SRC_ACC,
        ald_pkg::ALD_DST_ACC, 3'h0, 2'h1, 3'h4), 1'b0);
    vet(8'h84, 1'b1, mk(ald_pkg::ALD_OP_DIVIDE_ACC_AUX, ald_pkg::ALD_SRC_ACC,
        ald_pkg::ALD_DST_ACC, 3'h0, 2'h1, 3'h4), 1'b0);
    vet(8'hD4, 1'b1, mk(ald_pkg::ALD_OP_DECIMAL_ADJUST_ACC,
        ald_pkg::ALD_SRC_ACC, ald_pkg::ALD_DST_ACC, 3'h0, 2'h1,
        3'h1), 1'b0);
  endtask : specials

  // Neighbours outside the group, then an idle cycle
  task automatic refused;
    logic [7:0] outside [8] = '{8'h00, 8'h03, 8'h23, 8'h41, 8'h62, 8'hA2,
                                8'hE4, 8'hFF};
    foreach (outside[i]) vet(outside[i], 1'b1, IDLE, 1'b1);
    vet(8'h28, 1'b0, IDLE, 1'b0);
  endtask : refused

  // Reset in mid-stream, released at a falling edge; the opcode left
  // on the bus is decoded at the first edge after release
  task automatic mid_reset;
    ald_pkg::ald_ctrl_s e;
    u_fetch.send(8'h53, 1'b1);
    reset_i = 1'b1;
    @(posedge clk_i);
    #1;
    `CHK("ctrl_o", IDLE, ctrl)
    @(negedge clk_i);
    reset_i = 1'b0;
    @(posedge clk_i);
    #1;
    e = mk(ald_pkg::ALD_OP_BITWISE_AND_OP, ald_pkg::ALD_SRC_IMMEDIATE,
           ald_pkg::ALD_DST_DIRECT, 3'h0, 2'h3, 3'h2);
    `CHK("ctrl_o", e, ctrl)
    `CHK("unknown_o", 1'b0, unknown)
    vet(8'h52, 1'b1, mk(ald_pkg::ALD_OP_BITWISE_AND_OP, ald_pkg::ALD_SRC_ACC,
        ald_pkg::ALD_DST_DIRECT, 3'h0, 2'h2, 3'h1), 1'b0);
  endtask : mid_reset

  // Prints the counts and the verdict, then ends the run
  task automatic close_out;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    checks    = 0;
    reset_i   = 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    `CHK("ctrl_o", IDLE, ctrl)
    grp(4'h2, ald_pkg::ALD_OP_ADD);
    grp(4'h3, ald_pkg::ALD_OP_ADD_WITH_CARRY);
    grp(4'h9, ald_pkg::ALD_OP_SUBTRACT_WITH_BORROW);
    grp(4'h5, ald_pkg::ALD_OP_BITWISE_AND_OP);
    grp(4'h4, ald_pkg::ALD_OP_BITWISE_OR_OP);
    step_ops();
    to_direct();
    specials();
    refused();
    mid_reset();
    close_out();
  end

  // Bounded watchdog against a hang
  initial begin
    repeat (2000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end
endmodule : tb
